// ### verilog/edge_interrupt_input_unit.sv
// How it works
// - each of the six inputs can raise an interrupt on its transition
// - per input the edge is rising, falling or both
// - a serviced interrupt jumps to that group's own label register
// - each group has one role: interrupt, normal, counter or catch
// - normal inputs are sampled only at end-of-scan
// - the small variant cannot use groups five and six as interrupts
// - interrupts only work when the ladder language is selected
// - interrupts enabled by default; individually disabled and re-enabled
// - a per-group flag shows the interrupt is enabled
// - simultaneous requests are served lowest group first
// - a request during a handler waits until the handler completes
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
module edge_interrupt_input_unit #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [edge_irq_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [edge_irq_pkg::DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [edge_irq_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic [edge_irq_pkg::GROUPS-1:0] ext_input,
   output logic [edge_irq_pkg::GROUPS-1:0] normal_in,
   output logic handler_start,
   output edge_irq_pkg::handler_type handler,
   output logic irq
);
   import edge_irq_pkg::*;

   typedef enum logic [0:0] {
      DISP_IDLE = 1'b0,
      DISP_RUN = 1'b1
   } disp_type;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [GROUPS-1:0] role_mask(
      input group_cfg_type [GROUPS-1:0] c,
      input role_type r
   );
      logic [GROUPS-1:0] m;
      m = '0;
      for (int i = 0; i < GROUPS; i++) begin
         m[i] = (c[i].role == r);
      end
      return m;
   endfunction

   function automatic logic [31:0] merge_be(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] be
   );
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic ack;
   logic run;
   logic ladder;
   group_cfg_type [GROUPS-1:0] staged_cfg;
   group_cfg_type [GROUPS-1:0] active_cfg;
   logic [GROUPS-1:0] enabled;
   logic [GROUPS-1:0] irq_status;
   logic [GROUPS-1:0] irq_mask;
   logic [GROUPS-1:0] pending;
   logic [LABEL_W-1:0] label_reg [GROUPS];
   disp_type disp;

   logic [GROUPS-1:0] level;
   logic [GROUPS-1:0] pulse;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // one wait state: request seen, answered on the following edge
   wire access = read | write;
   assign waitrequest = access & ~ack;
   wire wr_go = write & ack;
   wire rd_take = read & ~ack;

   wire hit_ctrl = (address == OFS_CTRL);
   wire hit_role = (address == OFS_ROLE);
   wire hit_trig = (address == OFS_TRIG);
   wire hit_en_set = (address == OFS_EN_SET);
   wire hit_en_clr = (address == OFS_EN_CLR);
   wire hit_status = (address == OFS_IRQ_STATUS);
   wire hit_mask = (address == OFS_IRQ_MASK);
   wire hit_cmd = (address == OFS_CMD);
   wire [7:0] label_ofs = address - OFS_LABEL0;
   wire hit_label = (address >= OFS_LABEL0) && (label_ofs < 8'(GROUPS * 4))
                    && (address[1:0] == 2'b00);
   wire [2:0] label_idx = label_ofs[4:2];

   wire [31:0] wd_ctrl = merge_be({30'h0, ladder, run}, writedata, byteenable);
   wire [31:0] wd_role = merge_be(32'h0, writedata, byteenable);
   wire [31:0] wd_lo = merge_be(32'h0, writedata, byteenable);
   wire [31:0] wd_label = merge_be({16'h0, label_reg[label_idx]}, writedata,
                                   byteenable);

   wire do_ctrl = wr_go & hit_ctrl;
   wire do_load = do_ctrl & wd_ctrl[CTRL_LOAD_BIT];
   wire do_end_scan = wr_go & hit_cmd & wd_lo[CMD_END_SCAN_BIT];
   wire do_done = wr_go & hit_cmd & wd_lo[CMD_DONE_BIT];

   // ----------------------------------------------------------------
   // eligibility
   // ----------------------------------------------------------------
   wire [GROUPS-1:0] allowed = LARGE_VARIANT ? LARGE_ALLOWED : SMALL_ALLOWED;
   wire [GROUPS-1:0] irq_role = role_mask(active_cfg, ROLE_IRQ) & allowed;
   wire [GROUPS-1:0] normal_role = role_mask(active_cfg, ROLE_NORMAL);
   wire irq_on = run & ladder;
   wire [GROUPS-1:0] en_flags = enabled & irq_role & {GROUPS{irq_on}};
   wire [GROUPS-1:0] request = pulse & en_flags;

   // lowest group wins
   wire [GROUPS-1:0] grant = pending & (~pending + 6'h01);
   logic [2:0] grant_idx;
   always_comb begin
      grant_idx = 3'h0;
      for (int i = GROUPS - 1; i >= 0; i--) begin
         if (grant[i]) begin
            grant_idx = 3'(i);
         end
      end
   end
   wire dispatch = (disp == DISP_IDLE) && (pending != '0);
   wire [GROUPS-1:0] taken = dispatch ? grant : '0;

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (hit_ctrl) begin
         rd_mux = {30'h0, ladder, run};
      end else if (hit_role) begin
         for (int i = 0; i < GROUPS; i++) begin
            rd_mux[i*2 +: 2] = staged_cfg[i].role;
         end
      end else if (hit_trig) begin
         for (int i = 0; i < GROUPS; i++) begin
            rd_mux[i*2 +: 2] = staged_cfg[i].trig;
         end
      end else if (address == OFS_EN_FLAGS) begin
         rd_mux = {26'h0, en_flags};
      end else if (hit_status) begin
         rd_mux = {26'h0, irq_status};
      end else if (hit_mask) begin
         rd_mux = {26'h0, irq_mask};
      end else if (address == OFS_NORMAL_IN) begin
         rd_mux = {26'h0, normal_in};
      end else if (address == OFS_HANDLER) begin
         rd_mux[HANDLER_BUSY_BIT] = handler.busy;
         rd_mux[HANDLER_GROUP_POS +: 3] = handler.group;
         rd_mux[LABEL_W-1:0] = handler.label;
      end else if (address == OFS_PENDING) begin
         rd_mux = {26'h0, pending};
      end else if (hit_label) begin
         rd_mux = {16'h0, label_reg[label_idx]};
      end
   end

   // ----------------------------------------------------------------
   // bus handshake and read data
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack <= 1'b0;
         readdata <= 32'h0;
      end else begin
         ack <= access & ~ack;
         if (rd_take) begin
            readdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // control and configuration
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         run <= 1'b0;
         ladder <= 1'b0;
      end else if (do_ctrl) begin
         run <= wd_ctrl[CTRL_RUN_BIT];
         ladder <= wd_ctrl[CTRL_LADDER_BIT];
      end
   end

   // settings are staged; they only reach the logic on a program load
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         staged_cfg <= '0;
         active_cfg <= '0;
      end else begin
         for (int i = 0; i < GROUPS; i++) begin
            if (wr_go && hit_role) begin
               staged_cfg[i].role <= role_type'(wd_role[i*2 +: 2]);
            end
            if (wr_go && hit_trig) begin
               staged_cfg[i].trig <= trig_type'(wd_role[i*2 +: 2]);
            end
         end
         if (do_load) begin
            active_cfg <= staged_cfg;
         end
      end
   end

   // ----------------------------------------------------------------
   // enable flags, set and clear instructions
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         enabled <= RST_ENABLED;
      end else if (do_load) begin
         enabled <= RST_ENABLED;
      end else if (wr_go && hit_en_set) begin
         enabled <= enabled | wd_lo[GROUPS-1:0];
      end else if (wr_go && hit_en_clr) begin
         enabled <= enabled & ~wd_lo[GROUPS-1:0];
      end
   end

   // ----------------------------------------------------------------
   // labels
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < GROUPS; i++) begin
            label_reg[i] <= RST_LABEL;
         end
      end else if (wr_go && hit_label) begin
         label_reg[label_idx] <= wd_label[LABEL_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // normal inputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         normal_in <= '0;
      end else if (do_end_scan) begin
         normal_in <= level & normal_role;
      end
   end

   // ----------------------------------------------------------------
   // pending requests and dispatch
   // ----------------------------------------------------------------
   // a new edge in the same cycle as the grant of that group stays pending
   wire [GROUPS-1:0] next_pending = (pending & ~taken) | request;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pending <= '0;
      end else if (!irq_on) begin
         pending <= '0;
      end else begin
         pending <= next_pending;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         disp <= DISP_IDLE;
         handler <= '0;
         handler_start <= 1'b0;
      end else begin
         handler_start <= 1'b0;
         unique case (disp)
            DISP_IDLE: begin
               if (dispatch) begin
                  disp <= DISP_RUN;
                  handler.busy <= 1'b1;
                  handler.group <= grant_idx;
                  handler.label <= label_reg[grant_idx];
                  handler_start <= 1'b1;
               end
            end
            DISP_RUN: begin
               // handlers never overlap; wait for completion
               if (do_done) begin
                  disp <= DISP_IDLE;
                  handler.busy <= 1'b0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sticky event status, mask and interrupt line
   // ----------------------------------------------------------------
   wire [GROUPS-1:0] status_clr = (wr_go && hit_status) ? wd_lo[GROUPS-1:0] : '0;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_status <= '0;
         irq_mask <= RST_MASK;
      end else begin
         irq_status <= (irq_status & ~status_clr) | request;
         if (wr_go && hit_mask) begin
            irq_mask <= wd_lo[GROUPS-1:0];
         end
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ----------------------------------------------------------------
   // input edge detection
   // ----------------------------------------------------------------
   edge_detect_unit #(
      .N(GROUPS)
   ) u_edges (
      .sys_clk(sys_clk),
      .rst(rst),
      .din(ext_input),
      .cfg(active_cfg),
      .level(level),
      .pulse(pulse)
   );

endmodule

// ### verilog/edge_irq_pkg.sv
package edge_irq_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int GROUPS = 6;
   localparam int LABEL_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ROLE = 8'h04;
   localparam logic [7:0] OFS_TRIG = 8'h08;
   localparam logic [7:0] OFS_EN_SET = 8'h0C;
   localparam logic [7:0] OFS_EN_CLR = 8'h10;
   localparam logic [7:0] OFS_EN_FLAGS = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
   localparam logic [7:0] OFS_NORMAL_IN = 8'h20;
   localparam logic [7:0] OFS_CMD = 8'h24;
   localparam logic [7:0] OFS_HANDLER = 8'h28;
   localparam logic [7:0] OFS_PENDING = 8'h2C;
   localparam logic [7:0] OFS_LABEL0 = 8'h30;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_LADDER_BIT = 1;
   localparam int CTRL_LOAD_BIT = 2;
   localparam int CMD_END_SCAN_BIT = 0;
   localparam int CMD_DONE_BIT = 1;
   localparam int HANDLER_BUSY_BIT = 31;
   localparam int HANDLER_GROUP_POS = 16;

   // ----------------------------------------------------------------
   // reset values and allowed-group masks
   // ----------------------------------------------------------------
   localparam logic [5:0] RST_ENABLED = 6'h3F;
   localparam logic [5:0] RST_MASK = 6'h00;
   localparam logic [15:0] RST_LABEL = 16'h0000;
   localparam logic [5:0] LARGE_ALLOWED = 6'h3F;
   localparam logic [5:0] SMALL_ALLOWED = 6'h0F;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ROLE_NORMAL = 2'h0,
      ROLE_IRQ = 2'h1,
      ROLE_COUNTER = 2'h2,
      ROLE_CATCH = 2'h3
   } role_type;

   typedef enum logic [1:0] {
      TRIG_RISE = 2'h0,
      TRIG_FALL = 2'h1,
      TRIG_BOTH = 2'h2
   } trig_type;

   typedef struct packed {
      role_type role;
      trig_type trig;
   } group_cfg_type;

   typedef struct packed {
      logic busy;
      logic [2:0] group;
      logic [15:0] label;
   } handler_type;

endpackage

// ### verilog/edge_detect_unit.sv
`timescale 1ns/1ns
module edge_detect_unit #(
   parameter int N = 6
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [N-1:0] din,
   input edge_irq_pkg::group_cfg_type [N-1:0] cfg,
   output logic [N-1:0] level,
   output logic [N-1:0] pulse
);
   import edge_irq_pkg::*;

   logic [N-1:0] meta;
   logic [N-1:0] sync;
   logic [N-1:0] prev;

   // ----------------------------------------------------------------
   // synchroniser and compare of consecutive samples
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end else begin
         meta <= din;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level = sync;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_edge
         wire rise = sync[g] & ~prev[g];
         wire fall = ~sync[g] & prev[g];
         // one pulse per selected transition
         assign pulse[g] = (cfg[g].trig == TRIG_RISE) ? rise :
                           (cfg[g].trig == TRIG_FALL) ? fall :
                           (cfg[g].trig == TRIG_BOTH) ? (rise | fall) : 1'b0;
      end
   endgenerate

endmodule

// ### dv/edge_irq_monitor.sv
`timescale 1ns/1ns
module edge_irq_monitor
   import edge_irq_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [edge_irq_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [edge_irq_pkg::DATA_W-1:0] writedata,
   input wire logic [edge_irq_pkg::DATA_W-1:0] readdata,
   input wire logic waitrequest,
   input wire logic [edge_irq_pkg::GROUPS-1:0] normal_in,
   input wire logic handler_start,
   input edge_irq_pkg::handler_type handler,
   input wire logic irq
);
   // ----
   // bus and dispatch relations
   // ----
   localparam int ALLOWED_N = LARGE_VARIANT ? 6 : 4;
   wire logic acked = write && !waitrequest;
   wire logic done_wr = acked && address == OFS_CMD && writedata[CMD_DONE_BIT];
   wire logic scan_wr = acked && address == OFS_CMD && writedata[CMD_END_SCAN_BIT];
   wire logic unmask_wr = acked && address == OFS_IRQ_MASK && writedata[5:0] == 6'h00;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("waitrequest held past one wait");
   a_wait_idle: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest without request");
   a_read_stands: assert property (!$stable(readdata) |-> $past(read))
      else $error("readdata changed without read");
   a_start_single: assert property (handler_start |=> !handler_start)
      else $error("handler_start longer than one cycle");
   a_start_busy: assert property (handler_start |-> handler.busy)
      else $error("dispatch without busy");
   a_start_idle: assert property (handler_start |-> !$past(handler.busy))
      else $error("dispatch while a handler runs");
   a_busy_holds: assert property (handler.busy && !done_wr && !$past(done_wr)
      |=> $stable(handler)) else $error("handler changed before done");
   a_group_allowed: assert property (handler_start |-> handler.group < ALLOWED_N)
      else $error("dispatch of a group not allowed");
   a_normal_scan: assert property (!$stable(normal_in)
      |-> $past(scan_wr) || $past(scan_wr, 2)) else $error("normal_in moved off scan");
   a_mask_off: assert property (unmask_wr |=> !irq)
      else $error("irq high with mask cleared");
endmodule

bind edge_interrupt_input_unit edge_irq_monitor #(.LARGE_VARIANT(LARGE_VARIANT)) i_mon (
   .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .normal_in(normal_in), .handler_start(handler_start), .handler(handler), .irq(irq));

// ### dv/field_input_model.sv
`timescale 1ns/1ns
module field_input_model (
   input wire logic sys_clk,
   input wire logic [5:0] level,
   output logic [5:0] ext_input
);
   // ----
   // field lines
   // ----
   // lines retimed by one clock, so edges land on the rising clock edges of the unit
   logic [5:0] held = 6'h00;
   always @(posedge sys_clk) begin
      held <= level;
   end
   assign ext_input = held;
endmodule

// ### dv/tb.sv
`timescale 1ns/1ns
module tb;
   import edge_irq_pkg::*;
   // ----
   // signals
   // ----
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_type;
   logic sys_clk, rst, read, write, waitrequest, handler_start, irq;
   logic [ADDR_W-1:0] address;
   logic [DATA_W-1:0] writedata, readdata, rd, readdata_s, rd_s;
   logic [3:0] byteenable;
   logic [GROUPS-1:0] level, ext_input, normal_in;
   handler_type handler;
   int err_count, total_checks;
   row_type rows[8];
   logic [5:0] lv[7] = '{6'h01, 6'h00, 6'h02, 6'h00, 6'h04, 6'h00, 6'h38};
   logic [2:0] gx[7] = '{3'h0, 3'h7, 3'h7, 3'h1, 3'h2, 3'h2, 3'h3};

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   edge_interrupt_input_unit i_edge_interrupt_input_unit (.sys_clk(sys_clk), .rst(rst),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .ext_input(ext_input), .normal_in(normal_in), .handler_start(handler_start),
      .handler(handler), .irq(irq));
   field_input_model i_field_input_model (.sys_clk(sys_clk), .level(level),
      .ext_input(ext_input));
   // small variant on the same bus; only its read data is watched
   edge_interrupt_input_unit #(.LARGE_VARIANT(1'b0)) i_edge_interrupt_input_unit_small (
      .sys_clk(sys_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata_s),
      .waitrequest(), .ext_input(ext_input), .normal_in(), .handler_start(),
      .handler(), .irq());

   // ----
   // tasks
   // ----
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // master holds the request until waitrequest is seen low at an edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (waitrequest !== 1'b0);
      chk("bus cycles", 2, n);
      rd = readdata;
      rd_s = readdata_s;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task expect_start(input logic [2:0] g);
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < 12 && !seen; n++) begin
         @(negedge sys_clk);
         seen = (handler_start === 1'b1);
      end
      chk("start", g != 3'h7, seen);
      if (seen) begin
         chk("group", g, handler.group);
         chk("label", 16'hA5C0 + g, handler.label);
         chk("irq", 1, irq);
         bus(1, OFS_IRQ_MASK, 32'h0);
         @(negedge sys_clk);
         chk("irq masked", 0, irq);
         bus(1, OFS_IRQ_MASK, 32'h3F);
         // clear only this group so later pending groups keep their status
         bus(1, OFS_IRQ_STATUS, 32'h1 << g);
         bus(1, OFS_CMD, 32'h2);
      end
   endtask

   task flags(input logic [31:0] e);
      bus(0, OFS_EN_FLAGS, 0);
      chk("enabled flags", e, rd);
      chk("small flags", e & 32'(SMALL_ALLOWED), rd_s);
   endtask

   task drive(input logic [5:0] v);
      @(posedge sys_clk) level <= v;
   endtask

   // ----
   // sequence
   // ----
   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0;
      byteenable = 4'hF;
      level = 6'h00;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      bus(0, OFS_IRQ_MASK, 0);
      chk("mask reset", RST_MASK, rd);
      flags(0);
      chk("handler reset", 0, handler);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
         rows[i] = '{8'(OFS_LABEL0 + 4 * i), 32'hFFFF_A5C0 + i, 32'h0000_A5C0 + i};
      rows[6] = '{8'h48, 32'hFFFF_FFFF, 32'h0};
      rows[7] = '{OFS_IRQ_MASK, 32'h3F, 32'h3F};
      foreach (rows[i]) begin
         bus(1, rows[i].a, rows[i].d);
         bus(0, rows[i].a, 0);
         chk("register", rows[i].e, rd);
      end
      $display("test registers done");
      bus(1, OFS_ROLE, 32'h555);
      bus(1, OFS_TRIG, 32'h24);
      bus(1, OFS_CTRL, 32'h3);
      drive(6'h01);
      expect_start(3'h7);
      drive(6'h00);
      bus(1, OFS_CTRL, 32'h7);
      flags(32'h3F);
      foreach (lv[i]) begin
         drive(lv[i]);
         expect_start(gx[i]);
      end
      expect_start(3'h4);
      expect_start(3'h5);
      drive(6'h00);
      $display("test edges done");
      bus(1, OFS_EN_CLR, 32'h1);
      flags(32'h3E);
      drive(6'h01);
      expect_start(3'h7);
      drive(6'h00);
      bus(1, OFS_EN_SET, 32'h1);
      drive(6'h01);
      expect_start(3'h0);
      drive(6'h00);
      bus(1, OFS_CTRL, 32'h1);
      flags(0);
      drive(6'h01);
      expect_start(3'h7);
      drive(6'h00);
      bus(1, OFS_CTRL, 32'h3);
      $display("test enables done");
      bus(1, OFS_ROLE, 32'h554);
      bus(1, OFS_CTRL, 32'h7);
      flags(32'h3E);
      drive(6'h01);
      repeat (6) @(negedge sys_clk);
      chk("normal_in", 0, normal_in);
      bus(1, OFS_CMD, 32'h1);
      @(negedge sys_clk);
      chk("normal_in", 32'h1, normal_in);
      bus(0, OFS_NORMAL_IN, 0);
      chk("normal reg", 32'h1, rd);
      $display("test normal done");
      @(posedge sys_clk) rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      bus(0, OFS_LABEL0, 0);
      chk("label again", RST_LABEL, rd);
      flags(0);
      chk("normal_in again", 0, normal_in);
      $display("test second reset done");
      finish_test;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      finish_test;
   end
endmodule
